// ### hdl/cms_consts.vh
// constants of the carrier modulator sequencer
//
// Function
// - 12-bit down counter loaded from mark buffer
// - underflow closes gate, complement compare reopens
// - zero space register matches immediately, no space
// - match reloads counter and active space register
// - timer starts when enable bit set, runs to cycle end after it clears
// - time mode ticks at oscillator divided by eight
// - mark is buffer plus one ticks
// - gate opens with carrier, closes when carrier low
// - baseband: output high in mark, low space
// - prescale bit doubles mark and space durations
// - fsk mode counts carrier periods
// - fsk mark expiry toggles carrier register select, except with extended gap
// - fsk zero space switches without gap
// - extended gap makes whole periods pure space
// - cycle end sets flag, interrupt if enabled
// - space buffer copied every cycle end
// - status read then low-byte access clears flag
// - prescale selects oscillator rate or half oscillator rate
// - external mask blocks pin and keyscan interrupts
// - baseband holds carrier high, disables generator
// - mode bit one selects fsk, resets zero
// - clearing enable finishes cycle then forces low
// - cycle interrupt only when interrupt enable bit set; external interrupt ignores it
`ifndef CMS_CONSTS_VH
`define CMS_CONSTS_VH
`define CMS_OFS_CSR      4'h0
`define CMS_OFS_HIGH     4'h4
`define CMS_OFS_MARK_LO  4'h8
`define CMS_OFS_SPACE_LO 4'hc
`define CMS_BIT_EOC      7
`define CMS_BIT_HALF_RATE_PRESCALE     6
`define CMS_BIT_EXTERNAL_IRQ_MASK    5
`define CMS_BIT_EXTENDED_GAP_ENABLE    4
`define CMS_BIT_BASEBAND_SELECT     3
`define CMS_BIT_MODE     2
`define CMS_BIT_IE       1
`define CMS_BIT_EN       0
`define CMS_CSR_RESET    8'h00
`define CMS_TICK_DIV     3'h7
`endif

// ### hdl/cms_tick_gen.v
// tick generator for the modulator time base
`timescale 1ns/1ps
`include "cms_consts.vh"
module cms_tick_gen (
  input  wire sys_clk_in,
  input  wire rst_n_in,
  input  wire run_in,
  input  wire half_rate_in,
  input  wire fsk_in,
  input  wire carrier_in,
  output reg  tick_out
);
  reg [2:0] div_r;
  reg       half_r;
  reg       car_d_r;
  wire      pre_en;
  wire      car_fall;

  assign pre_en   = ~half_rate_in | half_r;
  assign car_fall = car_d_r & ~carrier_in;

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_r    <= 3'h0;
      half_r   <= 1'b0;
      car_d_r  <= 1'b0;
      tick_out <= 1'b0;
    end else begin
      car_d_r <= carrier_in;
      if (!run_in) begin
        // the load cycle counts as the first oscillator clock of the mark
        div_r    <= {2'b00, ~half_rate_in};
        half_r   <= 1'b1;
        tick_out <= 1'b0;
      end else begin
        half_r <= ~half_r;
        if (fsk_in) begin
          tick_out <= car_fall;
        end else begin
          if (pre_en)
            div_r <= div_r + 3'h1;
          tick_out <= pre_en && (div_r == `CMS_TICK_DIV);
        end
      end
    end
  end
endmodule // cms_tick_gen

// ### hdl/cms_modulator.v
// modulator sequencer with avalon register slave
`timescale 1ns/1ps
`include "cms_consts.vh"
module cms_modulator #(
  parameter CNT_W = 12
) (
  input  wire        sys_clk_in,
  input  wire        rst_n_in,
  input  wire [3:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  input  wire        carrier_in,
  input  wire        ext_irq_in,
  input  wire        keyscan_irq_in,
  output reg         carrier_gen_run_out,
  output reg         carrier_force_high_out,
  output reg         carrier_select_out,
  output reg         half_rate_out,
  output reg         mod_out,
  output reg         cycle_irq_out,
  output reg         ext_irq_out
);
  localparam ST_IDLE  = 3'b001;
  localparam ST_MARK  = 3'b010;
  localparam ST_SPACE = 3'b100;

  reg [7:0]       csr_r;
  reg [CNT_W-1:0] mark_period_buffer_r;
  reg [CNT_W-1:0] space_period_buffer_r;
  reg [CNT_W-1:0] active_space_register_r;
  reg [CNT_W-1:0] cnt_r;
  wire [CNT_W-1:0] cnt_dec;
  reg [2:0]       st_r;
  reg             gate_r;
  reg             ext_gap_r;
  reg             csr_read_r;
  reg             ack_r;
  reg             stop_req_r;
  wire            tick;
  wire            en_bit;
  wire            baseband_select;
  wire            fsk;
  wire            access;
  wire            rd_acc;
  wire            wr_acc;
  wire            lo_acc;
  wire            match;
  wire            underflow;
  wire            cycle_end;
  wire            running;
  reg  [31:0]     rd_mux;

  function sel;
    input [3:0] a;
    input [3:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  assign en_bit  = csr_r[`CMS_BIT_EN];
  assign baseband_select    = csr_r[`CMS_BIT_BASEBAND_SELECT];
  assign fsk     = csr_r[`CMS_BIT_MODE];
  assign running = (st_r != ST_IDLE);
  assign access  = (avs_read_in | avs_write_in) & ~ack_r;
  assign rd_acc  = access & avs_read_in;
  assign wr_acc  = access & avs_write_in & avs_byteenable_in[0];
  assign lo_acc  = access & (sel(avs_address_in, `CMS_OFS_MARK_LO) |
                             sel(avs_address_in, `CMS_OFS_SPACE_LO));
  assign cnt_dec = cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
  // complement of the next count equals active space; zero space matches at underflow
  assign match     = (~cnt_dec == active_space_register_r);
  assign underflow = tick && (cnt_r == {CNT_W{1'b0}});
  assign cycle_end = match && ((underflow && (st_r == ST_MARK)) ||
                               (tick && (st_r == ST_SPACE)));

  cms_tick_gen u_tick (
    .sys_clk_in   (sys_clk_in),
    .rst_n_in     (rst_n_in),
    .run_in       (running),
    .half_rate_in (csr_r[`CMS_BIT_HALF_RATE_PRESCALE]),
    .fsk_in       (fsk),
    .carrier_in   (carrier_in),
    .tick_out     (tick)
  );

  always @* begin
    rd_mux = 32'h0000_0000;
    case (1'b1)
      sel(avs_address_in, `CMS_OFS_CSR):
        rd_mux[7:0] = csr_r;
      sel(avs_address_in, `CMS_OFS_HIGH):
        rd_mux[7:0] = {mark_period_buffer_r[11:8], space_period_buffer_r[11:8]};
      sel(avs_address_in, `CMS_OFS_MARK_LO):
        rd_mux[7:0] = mark_period_buffer_r[7:0];
      sel(avs_address_in, `CMS_OFS_SPACE_LO):
        rd_mux[7:0] = space_period_buffer_r[7:0];
      default:
        rd_mux = 32'h0000_0000;
    endcase
  end

  // bus slave: one wait cycle, answer on second cycle
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_r               <= 1'b0;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
    end else begin
      ack_r               <= access;
      avs_waitrequest_out <= ~access;
      if (rd_acc)
        avs_readdata_out <= rd_mux;
    end
  end

  // registers and flag
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      csr_r                 <= `CMS_CSR_RESET;
      mark_period_buffer_r  <= {CNT_W{1'b0}};
      space_period_buffer_r <= {CNT_W{1'b0}};
      csr_read_r            <= 1'b0;
    end else begin
      if (access && sel(avs_address_in, `CMS_OFS_CSR))
        csr_read_r <= avs_read_in;
      else if (lo_acc)
        csr_read_r <= 1'b0;
      if (wr_acc) begin
        if (sel(avs_address_in, `CMS_OFS_CSR))
          csr_r[6:0] <= avs_writedata_in[6:0];
        if (sel(avs_address_in, `CMS_OFS_HIGH)) begin
          mark_period_buffer_r[11:8]  <= avs_writedata_in[7:4];
          space_period_buffer_r[11:8] <= avs_writedata_in[3:0];
        end
        if (sel(avs_address_in, `CMS_OFS_MARK_LO))
          mark_period_buffer_r[7:0] <= avs_writedata_in[7:0];
        if (sel(avs_address_in, `CMS_OFS_SPACE_LO))
          space_period_buffer_r[7:0] <= avs_writedata_in[7:0];
      end
      // set wins over clear
      if (cycle_end)
        csr_r[`CMS_BIT_EOC] <= 1'b1;
      else if (lo_acc && csr_read_r)
        csr_r[`CMS_BIT_EOC] <= 1'b0;
    end
  end

  // sequencer
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r                    <= ST_IDLE;
      cnt_r                   <= {CNT_W{1'b0}};
      active_space_register_r <= {CNT_W{1'b0}};
      gate_r                  <= 1'b0;
      ext_gap_r               <= 1'b0;
      stop_req_r              <= 1'b0;
      carrier_select_out      <= 1'b0;
    end else begin
      if (!en_bit && running)
        stop_req_r <= 1'b1;
      case (st_r)
        ST_IDLE: begin
          gate_r             <= 1'b0;
          stop_req_r         <= 1'b0;
          carrier_select_out <= 1'b0;
          if (en_bit) begin
            cnt_r                   <= mark_period_buffer_r;
            active_space_register_r <= space_period_buffer_r;
            ext_gap_r               <= csr_r[`CMS_BIT_EXTENDED_GAP_ENABLE];
            gate_r                  <= ~csr_r[`CMS_BIT_EXTENDED_GAP_ENABLE];
            st_r                    <= ST_MARK;
          end
        end
        ST_MARK: begin
          if (underflow) begin
            // outside baseband, gate stays open until the carrier is low
            gate_r <= gate_r && !baseband_select && carrier_in;
            st_r   <= ST_SPACE;
            cnt_r  <= cnt_dec;
            if (fsk && !ext_gap_r)
              carrier_select_out <= ~carrier_select_out;
          end else if (tick)
            cnt_r <= cnt_dec;
        end
        ST_SPACE: begin
          // close the gate while the carrier is low, or at once in baseband
          if (gate_r && (baseband_select || !carrier_in))
            gate_r <= 1'b0;
          if (tick)
            cnt_r <= cnt_dec;
        end
        default:
          st_r <= ST_IDLE;
      endcase
      // end of cycle: reload at the tick edge, no extra cycle spent
      if (cycle_end) begin
        cnt_r                   <= mark_period_buffer_r;
        active_space_register_r <= space_period_buffer_r;
        ext_gap_r               <= csr_r[`CMS_BIT_EXTENDED_GAP_ENABLE];
        if (stop_req_r || !en_bit) begin
          gate_r <= 1'b0;
          st_r   <= ST_IDLE;
        end else begin
          gate_r <= ~csr_r[`CMS_BIT_EXTENDED_GAP_ENABLE];
          st_r   <= ST_MARK;
        end
      end
    end
  end

  // outputs
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      carrier_gen_run_out    <= 1'b0;
      carrier_force_high_out <= 1'b0;
      half_rate_out          <= 1'b0;
      mod_out                <= 1'b0;
      cycle_irq_out          <= 1'b0;
      ext_irq_out            <= 1'b0;
    end else begin
      carrier_gen_run_out    <= running && !baseband_select;
      carrier_force_high_out <= baseband_select;
      half_rate_out          <= csr_r[`CMS_BIT_HALF_RATE_PRESCALE];
      mod_out                <= running && gate_r && (baseband_select || carrier_in);
      cycle_irq_out          <= csr_r[`CMS_BIT_EOC] && csr_r[`CMS_BIT_IE];
      ext_irq_out            <= (ext_irq_in | keyscan_irq_in) &&
                                !csr_r[`CMS_BIT_EXTERNAL_IRQ_MASK];
    end
  end
endmodule // cms_modulator

// ### sim/cms_modulator_monitor.sv
// port checker for the modulator sequencer
`timescale 1ns/1ps
module cms_modulator_monitor (
  input wire        sys_clk_in,
  input wire        rst_n_in,
  input wire        avs_read_in,
  input wire        avs_write_in,
  input wire [31:0] avs_readdata_out,
  input wire        avs_waitrequest_out,
  input wire        carrier_in,
  input wire        ext_irq_in,
  input wire        keyscan_irq_in,
  input wire        carrier_gen_run_out,
  input wire        carrier_force_high_out,
  input wire        half_rate_out,
  input wire        mod_out,
  input wire        ext_irq_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_bus_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("no bus answer");
  chk_bus_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer too long");
  chk_rdata_upper: assert property (avs_readdata_out[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_rdata_hold: assert property (!avs_read_in [*2] |-> $stable(avs_readdata_out))
    else $error("read data moved");
  chk_ctrl_hold: assert property (!avs_write_in [*3]
    |-> $stable(half_rate_out) && $stable(carrier_force_high_out)) else $error("ctrl moved");
  chk_baseband_select_stop: assert property (carrier_force_high_out [*2] |-> !carrier_gen_run_out)
    else $error("generator runs in baseband");
  chk_mask_idle: assert property (!(ext_irq_in || keyscan_irq_in) [*2] |-> !ext_irq_out)
    else $error("spurious external irq");
  chk_gated_low: assert property (!carrier_in && !carrier_force_high_out |=> !mod_out)
    else $error("output without carrier");
  cover property (!mod_out ##1 mod_out);
  cover property (carrier_force_high_out && mod_out);
  cover property ($rose(ext_irq_out));
endmodule // cms_modulator_monitor

bind cms_modulator cms_modulator_monitor u_cms_modulator_monitor (.*);

// ### sim/cms_carrier_model.sv
// carrier generator model driving the carrier level
`timescale 1ns/1ps
module cms_carrier_model #(parameter HALF0 = 3, parameter HALF1 = 5) (
  input  wire sys_clk_in,
  input  wire rst_n_in,
  input  wire run_in,
  input  wire force_high_in,
  input  wire select_in,
  output reg  carrier_out
);
  integer cnt;
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      carrier_out <= 1'b0;
      cnt <= 0;
    end else if (force_high_in) begin
      carrier_out <= 1'b1;
    end else if (!run_in) begin
      carrier_out <= 1'b0;
      cnt <= 0;
    end else if (cnt >= (select_in ? HALF1 : HALF0) - 1) begin
      carrier_out <= ~carrier_out;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // cms_carrier_model

// ### sim/cms_modulator_test.sv
// self-checking bench for the modulator sequencer
`timescale 1ns/1ps
module cms_modulator_test;
  reg         sys_clk_in, rst_n_in, rd, wr, ext, key;
  reg  [3:0]  adr, be;
  reg  [31:0] wdat, q;
  wire [31:0] rdat;
  wire        wreq, car, run, fh, sel, hr, mo, cirq, eirq;
  integer     err_count, num_checks, i, k, n, m, s, h, l;
  cms_modulator u_cms_modulator (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
    .avs_byteenable_in(be), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
    .carrier_in(car), .ext_irq_in(ext), .keyscan_irq_in(key), .carrier_gen_run_out(run),
    .carrier_force_high_out(fh), .carrier_select_out(sel), .half_rate_out(hr),
    .mod_out(mo), .cycle_irq_out(cirq), .ext_irq_out(eirq));
  cms_carrier_model u_cms_carrier_model (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .run_in(run), .force_high_in(fh), .select_in(sel), .carrier_out(car));
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  function integer ticks(input integer c, input integer p);
    ticks = c * 8 * (p + 1);
  endfunction
  task complete_run;
    begin
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task tmo(input integer c);
    if (c > 9000) begin
      err_count = err_count + 1;
      $display("MISMATCH %0t wait ran out", $time);
      complete_run;
    end
  endtask
  task bus(input w, input [3:0] a, input [7:0] d);
    begin
      n = 0;
      @(posedge sys_clk_in);
      rd <= !w;
      wr <= w;
      adr <= a;
      wdat <= {24'h0, d};
      @(posedge sys_clk_in);
      while (wreq !== 1'b0) begin
        n = n + 1;
        tmo(n * 200);
        @(posedge sys_clk_in);
      end
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask
  task lvl(input v, output integer c);
    begin
      c = 0;
      while (mo === v) begin
        @(posedge sys_clk_in);
        c = c + 1;
        tmo(c);
      end
    end
  endtask
  initial begin
    {rd, wr, ext, key, adr, wdat} = 0;
    be = 4'hf;
    err_count = 0;
    num_checks = 0;
    rst_n_in = 1'b0;
    i = $urandom(32889);
    repeat (4) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    bus(0, 4'h0, 0);
    chk(q, 0);
    chk({fh, sel, hr, mo, cirq}, 0);
    bus(0, 4'h2, 0);
    chk(q, 0);
    be <= 4'h0;
    bus(1, 4'h0, 8'h08);
    be <= 4'hf;
    bus(0, 4'h0, 0);
    chk(q, 0);
    for (i = 0; i < 8; i = i + 1) begin
      bus(1, 4'h0, i[2] ? 8'h20 : 8'h00);
      ext <= i[0];
      key <= i[1];
      repeat (3) @(posedge sys_clk_in);
      chk(eirq, (i[0] | i[1]) & !i[2]);
    end
    for (k = 0; k < 2; k = k + 1) begin
      m = 1 + $urandom % 15;
      s = 1 + $urandom % 15;
      bus(1, 4'h4, k ? 8'h10 : 8'h00);
      bus(1, 4'h8, m);
      bus(1, 4'hc, s);
      bus(1, 4'h0, k ? 8'h49 : 8'h09);
      lvl(1, h);
      lvl(0, l);
      lvl(1, h);
      lvl(0, l);
      chk(h, ticks(m + 1 + k * 256, k));
      chk(l, ticks(s, k));
      chk({hr, cirq}, {k[0], 1'b0});
      bus(1, 4'h0, k ? 8'h48 : 8'h08);
      repeat (9000) @(posedge sys_clk_in);
      chk(mo, 0);
    end
    bus(0, 4'h0, 0);
    chk(q[7], 1);
    bus(1, 4'h0, 8'h02);
    @(posedge sys_clk_in);
    chk(cirq, 1);
    bus(0, 4'h0, 0);
    bus(0, 4'h8, 0);
    bus(0, 4'h0, 0);
    chk(q[7], 0);
    chk(cirq, 0);
    bus(1, 4'h4, 8'h00);
    bus(1, 4'h8, 8'h02);
    bus(1, 4'hc, 8'h00);
    bus(1, 4'h0, 8'h05);
    {h, l} = 0;
    for (i = 0; i < 600; i = i + 1) begin
      @(posedge sys_clk_in);
      h = h + (sel !== u_cms_carrier_model.select_in ? 0 : mo);
      l = l + (i > 0 && sel !== q[0]);
      q[0] = sel;
    end
    chk(h > 0, 1);
    chk(l > 1, 1);
    complete_run;
  end
endmodule // cms_modulator_test
